// ===== verilog/arop_timer.sv
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
// How it works
// - Clock select 01 makes the lite timer tick clock the 12-bit counter.
// - Capture source select set takes capture from the lite capture pin.
// - Lite capture byte and 12-bit capture of one event form 20 bits.
// - One-pulse acts on counter two, dual mode, enable bit set only.
// - Trigger on lite capture pin edge chosen by the edge select bit.
// - Trigger clears counter two, output high, low at duty match.
// - Edges before the duty match are ignored; later ones restart.
// - Without trigger counter two wraps at reload to zero, output high.
// - One-pulse enable and edge select act at once when written.
// - Polarity bits invert outputs, updated at overflow with transfer set.
// - Trigger edge to counter reset takes three counter ticks.
// - Channel three priority: break, trigger, wrap, force, normal PWM.
// - Counter two overflow flag rises on every counter two wrap or trigger reset, not on break.
// - Duty three writes apply immediately in one-pulse mode.
// - Break resets counter two, duties and reload two; reprogram after.
// - Force bit loads FFFh, overflow transfers, then counts from reload, or from zero in one-pulse mode.
// - Force bits written one by software, cleared by hardware at overflow.
// - Timer runs in wait mode and freezes in halt mode.
module arop_timer
	import arop_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rstn,
	input  wire logic        clk_en,
	input  wire logic        halt_mode,
	input  wire logic        wait_mode,
	input  wire logic        break_active,
	input  wire logic        lite_tick,
	input  wire logic        fast_tick,
	input  wire logic [7:0]  lite_count,
	input  wire logic        own_capture_pin,
	input  wire logic        lite_capture_pin,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             channel_two_output,
	output logic             channel_three_output
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [1:0]  counter_clock_select_q;
	logic        capture_source_select_q;
	logic        capture_irq_enable_q;
	logic        capture_flag_q;
	logic        ovf1_flag_q;
	logic        second_counter_enable_q;
	logic        second_transfer_bit_q;
	logic        force_overflow_one_q;
	logic        force_overflow_two_q;
	logic        second_overflow_flag_q;
	logic        one_pulse_enable_q;
	logic        one_pulse_edge_select_q;
	logic [1:0]  channel_polarity_bits_q;
	logic [1:0]  pol_act_q;
	logic [11:0] reload1_q;
	logic [11:0] second_reload_value_q;
	logic [11:0] duty_two_q;
	logic [11:0] duty_three_q;
	logic [11:0] duty2_act_q;
	logic [11:0] duty3_act_q;
	logic [11:0] cnt1_q;
	logic [11:0] second_counter_q;
	logic [11:0] long_capture_register_q;
	logic [7:0]  lite_capture_register_q;
	logic [1:0]  own_sync_q;
	logic [1:0]  lite_sync_q;
	logic        cap_prev_q;
	logic        lite_prev_q;
	logic [1:0]  trig_stage_q;
	logic        past_duty_q;
	logic        raw2_q;
	logic        raw3_q;
	logic        aw_hold_q;
	logic        w_hold_q;
	logic [7:0]  aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;

	// ----------------------------------------------------------------
	// Register images
	// ----------------------------------------------------------------
	function automatic logic [31:0] reg_image(input logic [7:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (a)
			OFS_CTRL:
			begin
				v[CTRL_CLK_LSB +: 2] = counter_clock_select_q;
				v[CTRL_CSS_BIT]      = capture_source_select_q;
				v[CTRL_CIE_BIT]      = capture_irq_enable_q;
				v[CTRL_CF_BIT]       = capture_flag_q;
				v[CTRL_OVF1_BIT]     = ovf1_flag_q;
			end
			OFS_CTRL2:
			begin
				v[C2_ENA_BIT]  = second_counter_enable_q;
				v[C2_TRAN_BIT] = second_transfer_bit_q;
				v[C2_FRC1_BIT] = force_overflow_one_q;
				v[C2_FRC2_BIT] = force_overflow_two_q;
				v[C2_SECOND_OVERFLOW_FLAG_BIT] = second_overflow_flag_q;
			end
			OFS_CH3CSR:
			begin
				v[C3_OPEN_BIT] = one_pulse_enable_q;
				v[C3_EDGE_BIT] = one_pulse_edge_select_q;
				v[C3_POL2_BIT] = channel_polarity_bits_q[0];
				v[C3_POL3_BIT] = channel_polarity_bits_q[1];
			end
			OFS_RELOAD1: v[11:0] = reload1_q;
			OFS_RELOAD2: v[11:0] = second_reload_value_q;
			OFS_DUTY2:   v[11:0] = duty_two_q;
			OFS_DUTY3:   v[11:0] = duty_three_q;
			OFS_COUNT1:  v[11:0] = cnt1_q;
			OFS_COUNT2:  v[11:0] = second_counter_q;
			OFS_CAPTURE:
			begin
				v[11:0]             = long_capture_register_q;
				v[CAP_LITE_LSB +: 8] = lite_capture_register_q;
			end
			default: v = 32'h0000_0000;
		endcase
		return v;
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		return (a[1:0] == 2'h0) && (a <= OFS_CAPTURE);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	wire        aw_take = s_axi_awvalid && s_axi_awready;
	wire        w_take  = s_axi_wvalid && s_axi_wready;
	wire        wr_do   = aw_hold_q && w_hold_q && !s_axi_bvalid;
	wire        ar_take = s_axi_arvalid && s_axi_arready;
	wire        aw_hold_d = (aw_hold_q && !wr_do) || aw_take;
	wire        w_hold_d  = (w_hold_q && !wr_do) || w_take;
	wire        bvalid_d  = (s_axi_bvalid && !s_axi_bready) || wr_do;
	wire        rvalid_d  = (s_axi_rvalid && !s_axi_rready) || ar_take;
	wire [31:0] wr_word = merge(reg_image(aw_addr_q), w_data_q, w_strb_q);
	wire        wr_ok   = wr_do && mapped(aw_addr_q);
	wire        wr_ctrl = wr_ok && aw_addr_q == OFS_CTRL;
	wire        wr_c2   = wr_ok && aw_addr_q == OFS_CTRL2;
	wire        wr_c3   = wr_ok && aw_addr_q == OFS_CH3CSR;
	wire        wr_rl1  = wr_ok && aw_addr_q == OFS_RELOAD1;
	wire        wr_rl2  = wr_ok && aw_addr_q == OFS_RELOAD2;
	wire        wr_dt2  = wr_ok && aw_addr_q == OFS_DUTY2;
	wire        wr_dt3  = wr_ok && aw_addr_q == OFS_DUTY3;
	wire        rd_cap  = ar_take && s_axi_araddr == OFS_CAPTURE;
	wire        rd_c2   = ar_take && s_axi_araddr == OFS_CTRL2;
	wire        rd_ctrl = ar_take && s_axi_araddr == OFS_CTRL;

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			aw_hold_q     <= 1'b0;
			w_hold_q      <= 1'b0;
			aw_addr_q     <= 8'h00;
			w_data_q      <= 32'h0000_0000;
			w_strb_q      <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end
		else if (clk_en)
		begin
			aw_hold_q     <= aw_hold_d;
			w_hold_q      <= w_hold_d;
			s_axi_awready <= !aw_hold_d;
			s_axi_wready  <= !w_hold_d;
			s_axi_bvalid  <= bvalid_d;
			s_axi_arready <= !rvalid_d;
			s_axi_rvalid  <= rvalid_d;
			if (aw_take)
				aw_addr_q <= s_axi_awaddr;
			if (w_take)
			begin
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_do)
				s_axi_bresp <= mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
			if (ar_take)
			begin
				s_axi_rdata <= reg_image(s_axi_araddr);
				s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// ----------------------------------------------------------------
	// Clocking, pins and capture
	// ----------------------------------------------------------------
	// Halt and break stop the counters; wait mode leaves them alone.
	wire tick = !halt_mode && !break_active &&
		((counter_clock_select_q == CLK_LITE && lite_tick) ||
		 (counter_clock_select_q == CLK_CPU) ||
		 (counter_clock_select_q == CLK_FAST && fast_tick));
	wire unused_wait = wait_mode;
	wire cap_src  = capture_source_select_q ? lite_sync_q[1]
		: own_sync_q[1];
	wire cap_edge = cap_src != cap_prev_q;
	wire cap_set  = cap_edge && !capture_flag_q;
	wire lite_rise = lite_sync_q[1] && !lite_prev_q;
	wire lite_fall = !lite_sync_q[1] && lite_prev_q;
	wire op_on = one_pulse_enable_q && second_counter_enable_q;
	wire op_edge = op_on &&
		(one_pulse_edge_select_q ? lite_rise : lite_fall);

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			own_sync_q  <= 2'h0;
			lite_sync_q <= 2'h0;
			cap_prev_q  <= 1'b0;
			lite_prev_q <= 1'b0;
		end
		else if (clk_en)
		begin
			own_sync_q  <= {own_sync_q[0], own_capture_pin};
			lite_sync_q <= {lite_sync_q[0], lite_capture_pin};
			cap_prev_q  <= cap_src;
			lite_prev_q <= lite_sync_q[1];
		end
	end

	// Further edges are held off while the flag stands, so the last
	// captured pair always belongs to one event.
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			long_capture_register_q <= CNT_RESET;
			lite_capture_register_q <= 8'h00;
			capture_flag_q          <= 1'b0;
		end
		else if (clk_en)
		begin
			if (cap_set)
			begin
				long_capture_register_q <= cnt1_q;
				lite_capture_register_q <= lite_count;
			end
			capture_flag_q <= cap_set || (capture_flag_q && !rd_cap);
		end
	end

	// ----------------------------------------------------------------
	// Counter one
	// ----------------------------------------------------------------
	wire ovf1_evt = tick && cnt1_q == CNT_OVF;

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			cnt1_q <= CNT_RESET;
		else if (clk_en && tick)
		begin
			if (cnt1_q == CNT_OVF)
				cnt1_q <= reload1_q;
			else if (force_overflow_one_q)
				cnt1_q <= CNT_OVF;
			else
				cnt1_q <= cnt1_q + 12'h001;
		end
	end

	// ----------------------------------------------------------------
	// Counter two and one-pulse
	// ----------------------------------------------------------------
	wire        run2      = tick && second_counter_enable_q;
	wire        trig_fire = run2 && trig_stage_q == TRIG_TICKS;
	wire        op_wrap   = op_on && second_counter_q == second_reload_value_q;
	wire        wrap2     = second_counter_q == CNT_OVF || op_wrap;
	wire        second_overflow_flag_evt  = trig_fire || (run2 && wrap2);
	wire [11:0] duty3_eff = op_on ? duty_three_q : duty3_act_q;
	wire        hit3      = run2 && second_counter_q == duty3_eff;
	wire        hit2      = run2 && second_counter_q == duty2_act_q;
	wire        xfer      = second_overflow_flag_evt && second_transfer_bit_q;

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			second_counter_q <= CNT_RESET;
		else if (clk_en)
		begin
			if (break_active)
				second_counter_q <= CNT_RESET;
			else if (trig_fire)
				second_counter_q <= CNT_RESET;
			else if (run2 && force_overflow_two_q && !wrap2)
				second_counter_q <= CNT_OVF;
			else if (run2 && wrap2)
				second_counter_q <= op_on ? CNT_RESET
					: second_reload_value_q;
			else if (run2)
				second_counter_q <= second_counter_q + 12'h001;
		end
	end

	// Stage counts ticks after the accepted edge; stage zero means idle.
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			trig_stage_q <= 2'h0;
			past_duty_q  <= 1'b0;
		end
		else if (clk_en)
		begin
			if (!op_on || break_active || trig_fire)
				trig_stage_q <= 2'h0;
			else if (trig_stage_q == 2'h0 && op_edge && past_duty_q)
				trig_stage_q <= 2'h1;
			else if (trig_stage_q != 2'h0 && run2)
				trig_stage_q <= trig_stage_q + 2'h1;
			if (second_overflow_flag_evt || break_active)
				past_duty_q <= 1'b0;
			else if (hit3)
				past_duty_q <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Duty, reload, polarity and outputs
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			duty2_act_q <= CNT_RESET;
			duty3_act_q <= CNT_RESET;
			pol_act_q   <= 2'h0;
			raw2_q      <= 1'b0;
			raw3_q      <= 1'b0;
		end
		else if (clk_en)
		begin
			if (break_active)
			begin
				duty2_act_q <= CNT_RESET;
				duty3_act_q <= CNT_RESET;
			end
			else if (xfer)
			begin
				duty2_act_q <= duty_two_q;
				duty3_act_q <= duty_three_q;
				pol_act_q   <= channel_polarity_bits_q;
			end
			if (second_overflow_flag_evt)
				raw3_q <= 1'b1;
			else if (hit3)
				raw3_q <= 1'b0;
			if (second_overflow_flag_evt)
				raw2_q <= 1'b1;
			else if (hit2)
				raw2_q <= 1'b0;
		end
	end

	// Break drives both channels low ahead of everything else.
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			channel_two_output   <= 1'b0;
			channel_three_output <= 1'b0;
		end
		else if (clk_en)
		begin
			channel_two_output   <= !break_active && (raw2_q ^ pol_act_q[0]);
			channel_three_output <= !break_active && (raw3_q ^ pol_act_q[1]);
		end
	end

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			counter_clock_select_q  <= CLK_OFF;
			capture_source_select_q <= 1'b0;
			capture_irq_enable_q    <= 1'b0;
			ovf1_flag_q             <= 1'b0;
			second_counter_enable_q <= 1'b0;
			second_transfer_bit_q   <= 1'b1;
			force_overflow_one_q    <= 1'b0;
			force_overflow_two_q    <= 1'b0;
			second_overflow_flag_q  <= 1'b0;
			one_pulse_enable_q      <= 1'b0;
			one_pulse_edge_select_q <= 1'b0;
			channel_polarity_bits_q <= 2'h0;
			reload1_q               <= CNT_RESET;
			second_reload_value_q   <= CNT_RESET;
			duty_two_q              <= CNT_RESET;
			duty_three_q            <= CNT_RESET;
		end
		else if (clk_en)
		begin
			if (wr_ctrl)
			begin
				counter_clock_select_q  <= wr_word[CTRL_CLK_LSB +: 2];
				capture_source_select_q <= wr_word[CTRL_CSS_BIT];
				capture_irq_enable_q    <= wr_word[CTRL_CIE_BIT];
			end
			if (wr_c2)
			begin
				second_counter_enable_q <= wr_word[C2_ENA_BIT];
				second_transfer_bit_q   <= wr_word[C2_TRAN_BIT];
			end
			if (wr_c3)
			begin
				one_pulse_enable_q      <= wr_word[C3_OPEN_BIT];
				one_pulse_edge_select_q <= wr_word[C3_EDGE_BIT];
				channel_polarity_bits_q <= {wr_word[C3_POL3_BIT],
					wr_word[C3_POL2_BIT]};
			end
			if (wr_rl1)
				reload1_q <= wr_word[11:0];
			if (break_active)
			begin
				second_reload_value_q <= CNT_RESET;
				duty_two_q            <= CNT_RESET;
				duty_three_q          <= CNT_RESET;
			end
			else
			begin
				if (wr_rl2)
					second_reload_value_q <= wr_word[11:0];
				if (wr_dt2)
					duty_two_q <= wr_word[11:0];
				if (wr_dt3)
					duty_three_q <= wr_word[11:0];
			end
			// A software set wins over the hardware clear.
			force_overflow_one_q <= (wr_c2 && wr_word[C2_FRC1_BIT]) ||
				(force_overflow_one_q && !ovf1_evt);
			force_overflow_two_q <= (wr_c2 && wr_word[C2_FRC2_BIT]) ||
				(force_overflow_two_q && !second_overflow_flag_evt);
			second_overflow_flag_q <= second_overflow_flag_evt ||
				(second_overflow_flag_q && !rd_c2);
			ovf1_flag_q <= ovf1_evt || (ovf1_flag_q && !rd_ctrl);
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_lite_clock;
		@(posedge core_clk) disable iff (!rstn)
		(clk_en && counter_clock_select_q == CLK_LITE && !lite_tick)
		|=> $stable(cnt1_q);
	endproperty
	a_lite_clock: assert property (p_lite_clock)
		else $error("counter one moved without a lite tick");

	property p_capture_pair;
		@(posedge core_clk) disable iff (!rstn)
		(clk_en && cap_set) |=> long_capture_register_q == $past(cnt1_q)
		&& lite_capture_register_q == $past(lite_count);
	endproperty
	a_capture_pair: assert property (p_capture_pair)
		else $error("capture pair not taken from one event");

	property p_trig_reset;
		@(posedge core_clk) disable iff (!rstn)
		(clk_en && trig_fire && !break_active)
		|=> second_counter_q == CNT_RESET && raw3_q && second_overflow_flag_q;
	endproperty
	a_trig_reset: assert property (p_trig_reset)
		else $error("trigger did not restart counter two");

	property p_ignore_early;
		@(posedge core_clk) disable iff (!rstn)
		(clk_en && trig_stage_q == 2'h0 && !past_duty_q) |=>
		trig_stage_q == 2'h0;
	endproperty
	a_ignore_early: assert property (p_ignore_early)
		else $error("trigger accepted before duty match");

	// Software may drop the enable while a trigger is pending, so the
	// stage is only required to be idle one cycle later.
	property p_op_only;
		@(posedge core_clk) disable iff (!rstn)
		(clk_en && !op_on) |=> trig_stage_q == 2'h0;
	endproperty
	a_op_only: assert property (p_op_only)
		else $error("one-pulse active outside its mode");

	property p_pol_sync;
		@(posedge core_clk) disable iff (!rstn)
		(clk_en && !xfer) |=> $stable(pol_act_q);
	endproperty
	a_pol_sync: assert property (p_pol_sync)
		else $error("polarity changed without overflow transfer");

	property p_break;
		@(posedge core_clk) disable iff (!rstn)
		(clk_en && break_active) |=> second_counter_q == CNT_RESET &&
		second_reload_value_q == CNT_RESET && duty_three_q == CNT_RESET
		&& !channel_three_output;
	endproperty
	a_break: assert property (p_break)
		else $error("break did not clear counter two state");

	property p_force_load;
		@(posedge core_clk) disable iff (!rstn)
		(clk_en && run2 && !break_active && !trig_fire &&
		force_overflow_two_q && !wrap2) |=> second_counter_q == CNT_OVF
		&& force_overflow_two_q;
	endproperty
	a_force_load: assert property (p_force_load)
		else $error("force did not load overflow value");

	property p_force_clear;
		@(posedge core_clk) disable iff (!rstn)
		(clk_en && second_overflow_flag_evt && !(wr_c2 && wr_word[C2_FRC2_BIT]))
		|=> !force_overflow_two_q;
	endproperty
	a_force_clear: assert property (p_force_clear)
		else $error("force bit not cleared at overflow");

	property p_halt;
		@(posedge core_clk) disable iff (!rstn)
		halt_mode [*2] |-> $stable(cnt1_q) && $stable(second_counter_q);
	endproperty
	a_halt: assert property (p_halt)
		else $error("counters moved in halt");

	c_trigger: cover property (@(posedge core_clk) disable iff (!rstn)
		trig_fire);
	c_op_wrap: cover property (@(posedge core_clk) disable iff (!rstn)
		run2 && op_wrap);
	c_capture: cover property (@(posedge core_clk) disable iff (!rstn)
		cap_set && capture_source_select_q);

endmodule

// ===== shared/arop_pkg.sv
package arop_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_CTRL2   = 8'h04;
	localparam logic [7:0] OFS_CH3CSR  = 8'h08;
	localparam logic [7:0] OFS_RELOAD1 = 8'h0c;
	localparam logic [7:0] OFS_RELOAD2 = 8'h10;
	localparam logic [7:0] OFS_DUTY2   = 8'h14;
	localparam logic [7:0] OFS_DUTY3   = 8'h18;
	localparam logic [7:0] OFS_COUNT1  = 8'h1c;
	localparam logic [7:0] OFS_COUNT2  = 8'h20;
	localparam logic [7:0] OFS_CAPTURE = 8'h24;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_CLK_LSB  = 0;
	localparam int CTRL_CSS_BIT  = 2;
	localparam int CTRL_CIE_BIT  = 3;
	localparam int CTRL_CF_BIT   = 4;
	localparam int CTRL_OVF1_BIT = 5;
	localparam int C2_ENA_BIT    = 0;
	localparam int C2_TRAN_BIT   = 1;
	localparam int C2_FRC1_BIT   = 2;
	localparam int C2_FRC2_BIT   = 3;
	localparam int C2_SECOND_OVERFLOW_FLAG_BIT   = 4;
	localparam int C3_OPEN_BIT   = 0;
	localparam int C3_EDGE_BIT   = 1;
	localparam int C3_POL2_BIT   = 2;
	localparam int C3_POL3_BIT   = 3;
	localparam int CAP_LITE_LSB  = 12;

	// ----------------------------------------------------------------
	// Values and counts
	// ----------------------------------------------------------------
	localparam logic [11:0] CNT_RESET   = 12'h000;
	localparam logic [11:0] CNT_OVF     = 12'hfff;
	localparam logic [1:0]  CLK_OFF     = 2'h0;
	localparam logic [1:0]  CLK_LITE    = 2'h1;
	localparam logic [1:0]  CLK_CPU     = 2'h2;
	localparam logic [1:0]  CLK_FAST    = 2'h3;
	localparam logic [1:0]  TRIG_TICKS  = 2'h3;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage

// ===== sim/arop_pin_model.sv
`timescale 1ns/1ns
module arop_pin_model
(
	input  wire logic core_clk,
	input  wire logic fire,
	output logic      pin
);
	// The trigger line idles low, as if pulled down between pulses.
	initial pin = 1'b0;
	always @(posedge core_clk)
		pin <= fire;
endmodule

// ===== sim/test_autoreload_one_pulse_capture.sv
`timescale 1ns/1ns
`define CHK(a,b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
	$display("unexpected %0t got %h want %h", $time, a, b); end end
module test_autoreload_one_pulse_capture;
	import arop_pkg::*;
	typedef struct {logic [7:0] a; logic [31:0] d, e; logic [1:0] r;} arop_row_t;
	logic        core_clk = 1'b0, rstn = 1'b0, clk_en = 1'b1;
	logic        halt_mode = 1'b0, wait_mode = 1'b0, break_active = 1'b0;
	logic        lite_tick = 1'b0, fast_tick = 1'b0, fire = 1'b0;
	logic        own_capture_pin = 1'b0, lite_capture_pin;
	logic [7:0]  lite_count = 8'h5a, s_axi_awaddr = 8'h00;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd, sv;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs, bs;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid;
	logic        channel_two_output, channel_three_output;
	int          err_count = 0, n_tests = 0, k, h2, h3;
	arop_row_t   rows [5] = '{
		'{8'h10, 32'h1abc, 32'habc, RESP_OKAY},
		'{8'h14, 32'h5, 32'h5, RESP_OKAY},
		'{8'h18, 32'h4, 32'h4, RESP_OKAY},
		'{8'h1c, 32'h123, 32'h0, RESP_OKAY},
		'{8'h28, 32'h1, 32'h0, RESP_SLVERR}};

	always #5 core_clk = ~core_clk;
	always @(posedge core_clk)
		lite_tick <= ~lite_tick;
	arop_timer arop_timer_inst (.*);
	arop_pin_model arop_pin_model_inst (.core_clk, .fire,
		.pin(lite_capture_pin));

	// ----------------------------------------------------------------
	// Bus tasks
	// ----------------------------------------------------------------
	task report_and_stop;
		if (err_count == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Every polling loop goes through here, so a hang always ends the run.
	task tick;
		@(posedge core_clk);
		k++;
		if (k > 5000)
		begin
			err_count++;
			report_and_stop;
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		k = 0;
		do
		begin
			tick;
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		bs = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge core_clk);
	endtask
	task rdt(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		k = 0;
		do
		begin
			tick;
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge core_clk);
	endtask

	initial
	begin
		repeat (10) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge core_clk);
		rdt(OFS_CTRL2);
		`CHK(rd, 32'h2)
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].d);
			`CHK(bs, rows[i].r)
			rdt(rows[i].a);
			`CHK(rd, rows[i].e)
			`CHK(rs, rows[i].r)
		end
		wr(OFS_CTRL, 32'h2);
		wr(OFS_CTRL2, 32'hb);
		rdt(OFS_CTRL2);
		`CHK(rd[4:0], 5'h13)
		rdt(OFS_COUNT2);
		`CHK((rd[11:0] - 12'habc) < 12'h10, 1'b1)
		halt_mode <= 1'b1;
		rdt(OFS_COUNT2);
		sv = rd;
		rdt(OFS_COUNT2);
		halt_mode <= 1'b0;
		`CHK(rd, sv)
		wr(OFS_CH3CSR, 32'h3);
		// A trigger counts only after the duty match, so wait for channel three to rise and then fall.
		k = 0;
		while (!channel_three_output)
			tick;
		while (channel_three_output)
			tick;
		fire <= 1'b1;
		repeat (3) @(posedge core_clk);
		fire <= 1'b0;
		k = 0;
		while (!channel_three_output)
			tick;
		`CHK(k < 12, 1'b1)
		h2 = 1;
		h3 = 1;
		repeat (12)
		begin
			@(posedge core_clk);
			h2 += channel_two_output;
			h3 += channel_three_output;
		end
		// Duty four keeps counts zero to four high, five cycles in all.
		`CHK(h3 == 5, 1'b1)
		`CHK(h2 == 6, 1'b1)
		break_active <= 1'b1;
		repeat (3) @(posedge core_clk);
		`CHK({channel_two_output, channel_three_output}, 2'b00)
		break_active <= 1'b0;
		rdt(OFS_RELOAD2);
		`CHK(rd, 32'h0)
		wr(OFS_RELOAD2, 32'habc);
		wr(OFS_CH3CSR, 32'h0);
		wr(OFS_CTRL2, 32'h2);
		// Capture source change in the safe order, lite tick clocking.
		wr(OFS_CTRL, 32'h1);
		wr(OFS_CTRL, 32'h5);
		rdt(OFS_CAPTURE);
		wr(OFS_CTRL, 32'hd);
		wait_mode <= 1'b1;
		rdt(OFS_COUNT1);
		sv = rd;
		// Five frozen cycles: only the three enabled edges may count.
		clk_en <= 1'b0;
		repeat (5) @(posedge core_clk);
		clk_en <= 1'b1;
		rdt(OFS_COUNT1);
		`CHK(rd[11:0] - sv[11:0] - 12'h1 < 12'h2, 1'b1)
		fire <= 1'b1;
		repeat (3) @(posedge core_clk);
		fire <= 1'b0;
		repeat (5) @(posedge core_clk);
		rdt(OFS_CTRL);
		`CHK(rd[4:0], 5'h1d)
		lite_count <= 8'ha5;
		rdt(OFS_CAPTURE);
		`CHK(rd[19:12], 8'h5a)
		rstn <= 1'b0;
		@(posedge core_clk);
		rstn <= 1'b1;
		repeat (2) @(posedge core_clk);
		rdt(OFS_CTRL);
		`CHK(rd, 32'h0)
		report_and_stop;
	end
endmodule
